// [verilog/brot_cfg.svh]
// Constants for the byte rotate unit.
// Overview of operation
// - Plain left rotate: bits move up, old bit 7 to bit 0, result written to memory.
// - Left rotate to accumulator: rotated operand loads accumulator, memory left unchanged.
// - Left rotate through carry: old carry enters bit 0, bit 7 to carry, memory written.
// - Through-carry left rotate to accumulator: result in accumulator, carry from old bit 7.
// - Through-carry left rotate to accumulator never writes the memory operand.
// - Plain right rotate: bits move down, old bit 0 to bit 7, memory written.
`ifndef BROT_CFG_SVH
`define BROT_CFG_SVH
`define BROT_DATA_W 8
`define BROT_ACC_RST 8'h00
`define BROT_CARRY_RST 1'h0
`define BROT_MSB 7
`endif

// [verilog/brot_pkg.sv]
// Types shared by the byte rotate unit.
`default_nettype none
package brot_pkg;
  typedef enum logic [2:0] {
    BROT_NOP,
    BROT_ROTATE_LEFT_MEM,
    BROT_ROTATE_LEFT_TO_ACC,
    BROT_ROTATE_LEFT_CARRY_MEM,
    BROT_ROTATE_LEFT_CARRY_TO_ACC,
    BROT_ROTATE_RIGHT_MEM
  } brot_op_t;

  typedef struct packed {
    logic valid;
    brot_op_t op;
    logic [7:0] operand;
  } brot_req_t;

  typedef struct packed {
    logic mem_we;
    logic [7:0] mem_data;
  } brot_wb_t;
endpackage
`default_nettype wire

// [verilog/brot_unit.sv]
// Byte rotate unit: single-bit rotations with memory or accumulator write-back.
`include "brot_cfg.svh"
`default_nettype none
module brot_unit (
  input wire logic mclk_in,
  input wire logic rst_b_in,
  input wire brot_pkg::brot_req_t req_in,
  output brot_pkg::brot_wb_t wb_out,
  output logic [`BROT_DATA_W-1:0] acc_out,
  output logic carry_out
);
  // The accumulator and carry flag live here; the core reads them through the outputs.
  logic [`BROT_DATA_W-1:0] acc_r;
  logic [`BROT_DATA_W-1:0] acc_nxt;
  logic carry_r;
  logic carry_nxt;
  brot_pkg::brot_wb_t wb_r;
  brot_pkg::brot_wb_t wb_nxt;

  // Shifts a byte up one place; the caller chooses what enters the bottom bit.
  function automatic logic [`BROT_DATA_W-1:0] shift_up_fill(
    input logic [`BROT_DATA_W-1:0] value,
    input logic fill
  );
    return {value[`BROT_MSB-1:0], fill};
  endfunction

  // Shifts a byte down one place; the caller chooses what enters the top bit.
  function automatic logic [`BROT_DATA_W-1:0] shift_down_fill(
    input logic [`BROT_DATA_W-1:0] value,
    input logic fill
  );
    return {fill, value[`BROT_MSB:1]};
  endfunction

  // One decoder for every select keeps them one-hot, so the muxes below need no priority.
  function automatic logic op_is(
    input brot_pkg::brot_req_t req,
    input brot_pkg::brot_op_t code
  );
    return req.valid && (req.op == code);
  endfunction

  // Undefined codes and the no-operation code match no select, so they change nothing.
  wire [`BROT_DATA_W-1:0] opnd = req_in.operand;
  wire opnd_top = opnd[`BROT_MSB];
  wire opnd_bottom = opnd[0];
  wire do_left_mem = op_is(req_in, brot_pkg::BROT_ROTATE_LEFT_MEM);
  wire do_left_acc = op_is(req_in, brot_pkg::BROT_ROTATE_LEFT_TO_ACC);
  wire do_carry_mem = op_is(req_in, brot_pkg::BROT_ROTATE_LEFT_CARRY_MEM);
  wire do_carry_acc = op_is(req_in, brot_pkg::BROT_ROTATE_LEFT_CARRY_TO_ACC);
  wire do_right_mem = op_is(req_in, brot_pkg::BROT_ROTATE_RIGHT_MEM);

  // Plain rotates recycle the operand's own end bit; carry rotates feed the old flag in.
  wire [`BROT_DATA_W-1:0] rot_left = shift_up_fill(opnd, opnd_top);
  wire [`BROT_DATA_W-1:0] rot_left_carry = shift_up_fill(opnd, carry_r);
  wire [`BROT_DATA_W-1:0] rot_right = shift_down_fill(opnd, opnd_bottom);
  wire mem_dest = do_left_mem || do_carry_mem || do_right_mem;
  wire acc_dest = do_left_acc || do_carry_acc;
  wire carry_upd = do_carry_mem || do_carry_acc;

  // Memory is written only by memory-destination forms; accumulator forms leave it intact.
  assign wb_nxt.mem_we = mem_dest;
  assign wb_nxt.mem_data = do_right_mem ? rot_right :
    (do_carry_mem ? rot_left_carry : rot_left);
  assign acc_nxt = do_left_acc ? rot_left :
    (do_carry_acc ? rot_left_carry : acc_r);
  // The carry flag follows only the through-carry forms; every other request holds it.
  assign carry_nxt = carry_upd ? opnd_top : carry_r;

  // The write strobe is registered, so memory sees it one cycle after the request.
  // Back-to-back carry rotates therefore use the carry left by the previous request.
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      acc_r <= `BROT_ACC_RST;
      carry_r <= `BROT_CARRY_RST;
      wb_r <= '0;
    end else begin
      acc_r <= acc_nxt;
      carry_r <= carry_nxt;
      wb_r <= wb_nxt;
    end
  end

  assign wb_out = wb_r;
  assign acc_out = acc_r;
  assign carry_out = carry_r;

  // Plain left rotate writes the rotated byte back to memory.
  a_left_mem_result: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    do_left_mem
    |=> wb_out.mem_we && wb_out.mem_data == {$past(opnd[6:0]), $past(opnd_top)})
    else $error("left rotate result wrong");

  // Left rotate to the accumulator loads it and leaves memory alone.
  a_left_acc_value: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    do_left_acc
    |=> !wb_out.mem_we && acc_out == {$past(opnd[6:0]), $past(opnd_top)})
    else $error("left rotate to accumulator wrong");

  // Through-carry rotate to memory moves the old flag in and the top bit out.
  a_carry_mem_result: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    do_carry_mem
    |=> wb_out.mem_we && wb_out.mem_data == {$past(opnd[6:0]), $past(carry_r)}
      && carry_out == $past(opnd_top))
    else $error("left rotate through carry wrong");

  // Through-carry rotate to the accumulator computes the same nine-bit rotation.
  a_carry_acc_value: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    do_carry_acc
    |=> acc_out == {$past(opnd[6:0]), $past(carry_r)} && carry_out == $past(opnd_top))
    else $error("carry rotate to accumulator wrong");

  // A stray strobe here would corrupt an operand the program still expects to read.
  a_carry_acc_nowrite: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    do_carry_acc
    |=> !wb_out.mem_we)
    else $error("carry rotate to accumulator wrote memory");

  // Plain right rotate writes the rotated byte back to memory.
  a_right_mem_result: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    do_right_mem
    |=> wb_out.mem_we && wb_out.mem_data == {$past(opnd_bottom), $past(opnd[7:1])})
    else $error("right rotate result wrong");

  // Any request that is not a carry rotate must leave the flag as it was.
  a_flags_kept: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    !carry_upd
    |=> $stable(carry_out))
    else $error("carry changed by non-carry op");

  // Memory-destination forms never touch the accumulator.
  a_acc_kept: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    (do_left_mem || do_right_mem || do_carry_mem)
    |=> $stable(acc_out))
    else $error("accumulator changed by memory op");

  // Both carry forms load the flag from the operand's old top bit.
  a_carry_from_top: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    carry_upd
    |=> carry_out == $past(opnd_top))
    else $error("carry not taken from top bit");

  // Every write strobe must trace back to a memory-destination request.
  a_write_source: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    wb_out.mem_we
    |-> $past(mem_dest))
    else $error("memory written without a memory request");

  // An idle cycle changes no state and writes nothing.
  a_idle_quiet: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    !req_in.valid
    |=> !wb_out.mem_we && $stable(acc_out)
      && $stable(carry_out))
    else $error("idle cycle changed state");

  // The bit that leaves the top must reappear at the bottom.
  a_left_bottom_bit: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    do_left_mem
    |=> wb_out.mem_data[0] == $past(opnd_top))
    else $error("left rotate lost the top bit");

  // The bit that leaves the bottom must reappear at the top.
  a_right_top_bit: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    do_right_mem
    |=> wb_out.mem_data[`BROT_MSB] == $past(opnd_bottom))
    else $error("right rotate lost the bottom bit");

  // The old flag, not the new one, enters the accumulator's bottom bit.
  a_acc_bottom_carry: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    do_carry_acc
    |=> acc_out[0] == $past(carry_r))
    else $error("accumulator bottom bit not old carry");

  // Plain left rotate to the accumulator is not a carry form.
  a_left_acc_carry: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    do_left_acc
    |=> $stable(carry_out))
    else $error("carry changed by left rotate to accumulator");

  // Through-carry rotate to memory keeps the accumulator.
  a_carry_mem_acc: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    do_carry_mem
    |=> $stable(acc_out))
    else $error("accumulator changed by carry rotate to memory");

  // Accumulator forms of either kind never raise the write strobe.
  a_acc_dest_nowrite: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    acc_dest
    |=> !wb_out.mem_we)
    else $error("accumulator op wrote memory");

  // Plain right rotate leaves the flag alone.
  a_right_carry_kept: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    do_right_mem
    |=> $stable(carry_out))
    else $error("carry changed by right rotate");

  // Plain left rotate to memory leaves the flag alone.
  a_left_carry_kept: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    do_left_mem
    |=> $stable(carry_out))
    else $error("carry changed by left rotate");

  // Every memory-destination request must produce exactly one strobe in the next cycle.
  a_mem_ops_write: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    mem_dest
    |=> wb_out.mem_we)
    else $error("memory op did not write");
endmodule
`default_nettype wire

// [bench/brot_unit_test.sv]
// Self-checking testbench for the byte rotate unit.
`default_nettype none
module brot_unit_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_in = 1'b0;
  logic rst_b_in = 1'b0;
  brot_pkg::brot_req_t req_in = '0;
  brot_pkg::brot_wb_t wb_out;
  logic [7:0] acc_out;
  logic carry_out;
  int n_mismatch = 0;
  int total_checks = 0;
  brot_unit brot_unit_inst (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .req_in(req_in),
    .wb_out(wb_out), .acc_out(acc_out), .carry_out(carry_out));
  always #10 mclk_in = ~mclk_in;
  task stop_test();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Memory data only means something with the strobe, so it is masked when no write is due.
  task run(input brot_pkg::brot_op_t op, input logic [7:0] d, input logic [17:0] e);
    @(posedge mclk_in);
    req_in <= {1'b1, op, d};
    @(posedge mclk_in);
    req_in.valid <= 1'b0;
    #1;
    total_checks++;
    if ({wb_out.mem_we, wb_out.mem_data & {8{wb_out.mem_we}}, acc_out, carry_out} !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %0t op %0d got %h", $time, op, {wb_out, acc_out, carry_out});
    end
  endtask
  task test_mem();
    run(brot_pkg::BROT_ROTATE_LEFT_MEM, 8'h81, {1'b1, 8'h03, 8'h00, 1'b0});
    run(brot_pkg::BROT_ROTATE_RIGHT_MEM, 8'h01, {1'b1, 8'h80, 8'h00, 1'b0});
    run(brot_pkg::BROT_ROTATE_LEFT_CARRY_MEM, 8'h81, {1'b1, 8'h02, 8'h00, 1'b1});
    run(brot_pkg::BROT_ROTATE_RIGHT_MEM, 8'h02, {1'b1, 8'h01, 8'h00, 1'b1});
    run(brot_pkg::BROT_ROTATE_LEFT_CARRY_MEM, 8'h40, {1'b1, 8'h81, 8'h00, 1'b0});
    $display("test_mem done");
  endtask
  task test_acc();
    run(brot_pkg::BROT_ROTATE_LEFT_TO_ACC, 8'h81, {1'b0, 8'h00, 8'h03, 1'b0});
    run(brot_pkg::BROT_ROTATE_LEFT_CARRY_TO_ACC, 8'h80, {1'b0, 8'h00, 8'h00, 1'b1});
    run(brot_pkg::BROT_ROTATE_LEFT_CARRY_TO_ACC, 8'h01, {1'b0, 8'h00, 8'h03, 1'b0});
    run(brot_pkg::BROT_ROTATE_LEFT_TO_ACC, 8'hc0, {1'b0, 8'h00, 8'h81, 1'b0});
    $display("test_acc done");
  endtask
  task test_idle();
    run(brot_pkg::BROT_NOP, 8'hff, {1'b0, 8'h00, 8'h81, 1'b0});
    $display("test_idle done");
  endtask
  initial begin
    repeat (20) @(posedge mclk_in);
    rst_b_in <= 1'b1;
    test_mem();
    test_acc();
    test_idle();
    stop_test();
  end
  // About twenty cycles of work, so ten microseconds only trips on a hang.
  initial begin
    #10us;
    n_mismatch++;
    stop_test();
  end
endmodule
`default_nettype wire
